/* File: design/acil_adc_irq_ctrl.v */
`timescale 1ns/100ps
`include "acil_defines.vh"

// Operation
// - Two-bit select routes one of four sources
// - Control bit seven picks battery voltage span
// - Control bit six picks charge current span
// - Converter off after reset, runs while enabled
// - Start bit rising from zero starts conversion
// - Completion sets ready and conversion interrupt together
// - Result code spans selected input range fully
// - Unmasked event pulls open-drain request pin low
// - Adapter attach and detach raise events zero, one
// - USB attach and detach raise events two, three
// - Battery dropping below threshold raises event four
// - Over-temperature alarm raises event five
// - Finished conversion raises event six
// - Charger safety timer expiry raises event seven
// - Masked events still recorded, pin untouched
// - Reading flag register clears all its bits
// - Events during clearing read held as pending
// - Pending events pull pin low again after release
// - Events captured in standby, held for service
// - First enable waits about two milliseconds warm-up
// - Mask bit one lets source pull pin, resets zero
// - Flag bit n set when source n requested
module acil_adc_irq_ctrl #(
  parameter [`ACIL_WARM_W-1:0] WARMUP_CYCLES = `ACIL_WARMUP_CYC,
  parameter [6:0]              DEV_ADDR      = `ACIL_DEV_ADDR
) (
  // Clock, reset, enable
  input  wire       clk,
  input  wire       rst_b,
  input  wire       ce,
  // Serial register link
  input  wire       scl,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe,
  // Open-drain request pin
  output reg        interrupt_request_pin_n_o,
  output reg        interrupt_request_pin_n_oe,
  // Analog converter core
  output reg        converter_power_en,
  output reg  [1:0] adc_source_sel,
  output reg        battery_voltage_span,
  output reg        charge_current_span,
  output reg        conversion_start,
  input  wire       converter_done,
  input  wire       converter_overflow,
  input  wire [7:0] converter_data,
  // Supervisor event levels
  input  wire       adapter_input,
  input  wire       usb_power,
  input  wire       battery_low,
  input  wire       thermal_alarm,
  input  wire       charge_timer_expired
);

  // Serial states, one-hot
  localparam [6:0] I_IDLE = 7'h01;
  localparam [6:0] I_ADDR = 7'h02;
  localparam [6:0] I_AACK = 7'h04;
  localparam [6:0] I_WR   = 7'h08;
  localparam [6:0] I_WACK = 7'h10;
  localparam [6:0] I_RD   = 7'h20;
  localparam [6:0] I_RACK = 7'h40;

  // Converter states, one-hot
  localparam [2:0] C_IDLE = 3'h1;
  localparam [2:0] C_WARM = 3'h2;
  localparam [2:0] C_BUSY = 3'h4;

  wire [`ACIL_SYNC_W-1:0] s_lvl;   // Settled input levels
  wire [`ACIL_SYNC_W-1:0] s_rise;  // Rising edges
  wire [`ACIL_SYNC_W-1:0] s_fall;  // Falling edges

  reg  [6:0]  i_state;      // Serial state
  reg  [3:0]  bit_cnt;      // Bits seen in current byte
  reg  [7:0]  shreg;        // Incoming byte
  reg  [7:0]  tx;           // Outgoing byte
  reg  [7:0]  ptr;          // Register pointer
  reg         have_ptr;     // Pointer byte already taken
  reg         rw;           // Direction of this transfer
  reg         master_nack;  // Master refused more data
  reg         read_window;  // Flag read in progress

  reg  [2:0]  c_state;      // Converter state
  reg  [`ACIL_WARM_W-1:0] warm_cnt; // Warm-up cycle count
  reg         warmed;       // Warm-up done once
  reg         start_queued; // Start asked during warm-up
  reg         start_bit;    // Stored start control bit
  reg         data_ready;   // Result valid
  reg         overflow;     // Overflow of last result
  reg  [7:0]  result;       // Last conversion result
  reg         ev_conv;      // Conversion done pulse

  reg  [7:0]  event_mask_reg;       // Mask, one enables
  reg  [7:0]  flag;                 // Visible event flags
  reg  [7:0]  pending_event_buffer; // Hidden holding buffer

  reg  [7:0]  rdata;        // Read mux out
  wire [7:0]  ev;           // Event pulses this cycle
  wire        start_cond;   // Start on the link
  wire        stop_cond;    // Stop on the link
  wire        do_load;      // Load next read byte
  wire        load_flag;    // That byte is the flag byte
  wire        win_end;      // Flag read finished
  wire        wr_data;      // Data byte write strobe
  wire        start_req;    // Start written as a fresh one
  wire        en_now;       // Enable as this cycle's write leaves it

  // Link pins, event levels and converter done pass two stages first
  acil_sync #(
    .W(`ACIL_SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .async_in ({scl, sda_i, adapter_input, usb_power, battery_low,
                thermal_alarm, charge_timer_expired, converter_done}),
    .level    (s_lvl),
    .rise     (s_rise),
    .fall     (s_fall)
  );

  // Link framing; start and stop seen while clock high
  assign start_cond = s_fall[`ACIL_S_SDA] & s_lvl[`ACIL_S_SCL];
  assign stop_cond  = s_rise[`ACIL_S_SDA] & s_lvl[`ACIL_S_SCL];
  assign do_load    = s_fall[`ACIL_S_SCL] &
                      (((i_state == I_AACK) & rw) |
                       ((i_state == I_RACK) & ~master_nack));
  assign load_flag  = do_load & (ptr == `ACIL_REG_FLAG);
  assign win_end    = read_window & (start_cond | stop_cond |
                      (s_fall[`ACIL_S_SCL] & (i_state == I_RACK)));
  assign wr_data    = s_fall[`ACIL_S_SCL] & (i_state == I_WR) &
                      (bit_cnt == `ACIL_BYTE_BITS) & have_ptr;
  assign start_req  = wr_data & (ptr == `ACIL_REG_CTRL) &
                      shreg[`ACIL_B_START] & ~start_bit;
  // A start in the enabling write itself must not be lost
  assign en_now     = (wr_data & (ptr == `ACIL_REG_CTRL)) ? shreg[`ACIL_B_ENABLE] :
                      converter_power_en;

  // Event sources; the caller orders servicing itself
  assign ev[`ACIL_EV_ADAPT_ON]  = s_rise[`ACIL_S_ADAPT];
  assign ev[`ACIL_EV_ADAPT_OFF] = s_fall[`ACIL_S_ADAPT];
  assign ev[`ACIL_EV_USB_ON]    = s_rise[`ACIL_S_USB];
  assign ev[`ACIL_EV_USB_OFF]   = s_fall[`ACIL_S_USB];
  assign ev[`ACIL_EV_BATT_LOW]  = s_rise[`ACIL_S_BATT];
  assign ev[`ACIL_EV_THERMAL]   = s_rise[`ACIL_S_THERM];
  assign ev[`ACIL_EV_CONV_DONE] = ev_conv;
  assign ev[`ACIL_EV_CHG_TIMER] = s_rise[`ACIL_S_TIMER];

  // Read mux; unmapped pointers read zero
  always @* begin
    if (ptr == `ACIL_REG_CTRL) begin
      rdata = {battery_voltage_span, charge_current_span, overflow,
               data_ready, start_bit, converter_power_en, adc_source_sel};
    end else if (ptr == `ACIL_REG_RESULT) begin
      rdata = result;
    end else if (ptr == `ACIL_REG_MASK) begin
      rdata = event_mask_reg;
    end else if (ptr == `ACIL_REG_FLAG) begin
      rdata = flag;
    end else begin
      rdata = `ACIL_RST_BYTE;
    end
  end

  // Serial slave: sample on clock rise, drive on clock fall
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      i_state     <= I_IDLE;
      bit_cnt     <= `ACIL_BIT_ZERO;
      shreg       <= `ACIL_RST_BYTE;
      tx          <= `ACIL_RST_BYTE;
      ptr         <= `ACIL_RST_BYTE;
      have_ptr    <= 1'b0;
      rw          <= 1'b0;
      master_nack <= 1'b0;
      read_window <= 1'b0;
      sda_o       <= 1'b0;
      sda_oe      <= 1'b0;
    end else if (ce) begin
      sda_o <= 1'b0; // Open drain only ever pulls low
      if (start_cond) begin
        // Repeated start keeps the pointer
        i_state     <= I_ADDR;
        bit_cnt     <= `ACIL_BIT_ZERO;
        have_ptr    <= 1'b0;
        sda_oe      <= 1'b0;
        read_window <= 1'b0;
      end else if (stop_cond) begin
        i_state     <= I_IDLE;
        sda_oe      <= 1'b0;
        read_window <= 1'b0;
      end else if (s_rise[`ACIL_S_SCL]) begin
        // Shift data in; during reads this counts sent bits
        if ((i_state == I_ADDR) | (i_state == I_WR) |
            (i_state == I_RD)) begin
          shreg   <= {shreg[6:0], s_lvl[`ACIL_S_SDA]};
          bit_cnt <= bit_cnt + `ACIL_BIT_ONE;
        end
        if (i_state == I_RACK) begin
          master_nack <= s_lvl[`ACIL_S_SDA];
        end
      end else if (s_fall[`ACIL_S_SCL]) begin
        case (i_state)
          I_ADDR: begin
            if (bit_cnt == `ACIL_BYTE_BITS) begin
              // Only our own address is acknowledged
              if (shreg[7:1] == DEV_ADDR) begin
                sda_oe  <= 1'b1;
                rw      <= shreg[0];
                i_state <= I_AACK;
              end else begin
                i_state <= I_IDLE;
              end
            end
          end
          I_AACK: begin
            bit_cnt <= `ACIL_BIT_ZERO;
            if (rw) begin
              // First read byte from current pointer
              tx          <= rdata;
              sda_oe      <= ~rdata[7];
              ptr         <= ptr + `ACIL_ONE_BYTE;
              read_window <= load_flag;
              i_state     <= I_RD;
            end else begin
              sda_oe  <= 1'b0;
              i_state <= I_WR;
            end
          end
          I_WR: begin
            if (bit_cnt == `ACIL_BYTE_BITS) begin
              sda_oe  <= 1'b1;
              i_state <= I_WACK;
              if (have_ptr) begin
                ptr <= ptr + `ACIL_ONE_BYTE; // Auto-increment
              end else begin
                ptr      <= shreg;
                have_ptr <= 1'b1;
              end
            end
          end
          I_WACK: begin
            sda_oe  <= 1'b0;
            bit_cnt <= `ACIL_BIT_ZERO;
            i_state <= I_WR;
          end
          I_RD: begin
            if (bit_cnt == `ACIL_BYTE_BITS) begin
              sda_oe  <= 1'b0; // Master answers now
              i_state <= I_RACK;
            end else begin
              tx     <= {tx[6:0], 1'b0};
              sda_oe <= ~tx[6];
            end
          end
          I_RACK: begin
            bit_cnt <= `ACIL_BIT_ZERO;
            if (master_nack) begin
              read_window <= 1'b0;
              i_state     <= I_IDLE;
            end else begin
              tx          <= rdata;
              sda_oe      <= ~rdata[7];
              ptr         <= ptr + `ACIL_ONE_BYTE;
              read_window <= load_flag;
              i_state     <= I_RD;
            end
          end
          default: begin
            i_state <= I_IDLE;
          end
        endcase
      end
    end
  end

  // Writable control and mask fields
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      battery_voltage_span <= 1'b0;
      charge_current_span  <= 1'b0;
      start_bit            <= 1'b0;
      converter_power_en   <= 1'b0;
      adc_source_sel       <= `ACIL_RST_SRC;
      event_mask_reg       <= `ACIL_RST_BYTE;
    end else if (ce) begin
      if (wr_data & (ptr == `ACIL_REG_CTRL)) begin
        // Spans and source drive the analog front end directly
        battery_voltage_span <= shreg[`ACIL_B_VSPAN];
        charge_current_span  <= shreg[`ACIL_B_ISPAN];
        start_bit            <= shreg[`ACIL_B_START];
        converter_power_en   <= shreg[`ACIL_B_ENABLE];
        adc_source_sel       <= shreg[`ACIL_F_SRC];
      end else if (wr_data & (ptr == `ACIL_REG_MASK)) begin
        event_mask_reg <= shreg;
      end
    end
  end

  // Converter sequencing: warm-up, start, completion
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c_state          <= C_IDLE;
      warm_cnt         <= {`ACIL_WARM_W{1'b0}};
      warmed           <= 1'b0;
      start_queued     <= 1'b0;
      data_ready       <= 1'b0;
      overflow         <= 1'b0;
      result           <= `ACIL_RST_BYTE;
      conversion_start <= 1'b0;
      ev_conv          <= 1'b0;
    end else if (ce) begin
      conversion_start <= 1'b0;
      ev_conv          <= 1'b0;
      case (c_state)
        C_IDLE: begin
          if (en_now & ~warmed) begin
            // Enables wait until one warm-up has run to its end
            warm_cnt     <= {`ACIL_WARM_W{1'b0}};
            start_queued <= start_req;
            c_state      <= C_WARM;
          end else if (en_now & start_req) begin
            conversion_start <= 1'b1;
            data_ready       <= 1'b0;
            c_state          <= C_BUSY;
          end
        end
        C_WARM: begin
          if (~en_now) begin
            c_state <= C_IDLE;
          end else if (warm_cnt == WARMUP_CYCLES - `ACIL_WARM_ONE) begin
            warmed <= 1'b1;
            if (start_queued | start_req) begin
              conversion_start <= 1'b1;
              data_ready       <= 1'b0;
              c_state          <= C_BUSY;
            end else begin
              c_state <= C_IDLE;
            end
          end else begin
            warm_cnt <= warm_cnt + `ACIL_WARM_ONE;
            if (start_req) begin
              start_queued <= 1'b1;
            end
          end
        end
        C_BUSY: begin
          if (~en_now) begin
            c_state <= C_IDLE;
          end else if (s_rise[`ACIL_S_DONE]) begin
            // Data is held steady by the core once done rises
            result     <= converter_data;
            overflow   <= converter_overflow;
            data_ready <= 1'b1;
            ev_conv    <= 1'b1;
            c_state    <= C_IDLE;
          end
        end
        default: begin
          c_state <= C_IDLE;
        end
      endcase
    end
  end

  // Flags and pending buffer; capture never stops, even in standby
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag                 <= `ACIL_RST_BYTE;
      pending_event_buffer <= `ACIL_RST_BYTE;
    end else if (ce) begin
      if (load_flag) begin
        // Snapshot taken this cycle; newcomers go to pending
        flag                 <= `ACIL_RST_BYTE;
        pending_event_buffer <= pending_event_buffer | ev;
      end else if (win_end) begin
        flag                 <= flag | pending_event_buffer | ev;
        pending_event_buffer <= `ACIL_RST_BYTE;
      end else if (read_window) begin
        pending_event_buffer <= pending_event_buffer | ev;
      end else begin
        flag <= flag | ev;
      end
    end
  end

  // Request pin: pulled while any unmasked flag stands
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_request_pin_n_o  <= 1'b0;
      interrupt_request_pin_n_oe <= 1'b0;
    end else if (ce) begin
      interrupt_request_pin_n_o  <= 1'b0;
      // Pending moves into flags at read end, so pin falls again
      interrupt_request_pin_n_oe <= |(flag & event_mask_reg);
    end
  end

endmodule // acil_adc_irq_ctrl

/* File: design/acil_defines.vh */
`ifndef ACIL_DEFINES_VH
`define ACIL_DEFINES_VH

// Register pointer values seen on the serial link
`define ACIL_REG_CTRL      8'h0A
`define ACIL_REG_RESULT    8'h0B
`define ACIL_REG_MASK      8'h0C
`define ACIL_REG_FLAG      8'h0D

// Converter control field positions
`define ACIL_B_VSPAN       7
`define ACIL_B_ISPAN       6
`define ACIL_B_OVF         5
`define ACIL_B_READY       4
`define ACIL_B_START       3
`define ACIL_B_ENABLE      2
`define ACIL_F_SRC         1:0

// Reset and fill values
`define ACIL_RST_BYTE      8'h00
`define ACIL_RST_SRC       2'h0
`define ACIL_ONE_BYTE      8'h01

// Event bit positions in flag, mask and pending
`define ACIL_EV_ADAPT_ON   0
`define ACIL_EV_ADAPT_OFF  1
`define ACIL_EV_USB_ON     2
`define ACIL_EV_USB_OFF    3
`define ACIL_EV_BATT_LOW   4
`define ACIL_EV_THERMAL    5
`define ACIL_EV_CONV_DONE  6
`define ACIL_EV_CHG_TIMER  7

// Positions in the synchroniser vector
`define ACIL_S_SCL         7
`define ACIL_S_SDA         6
`define ACIL_S_ADAPT       5
`define ACIL_S_USB         4
`define ACIL_S_BATT        3
`define ACIL_S_THERM       2
`define ACIL_S_TIMER       1
`define ACIL_S_DONE        0
`define ACIL_SYNC_W        8

// Serial framing
`define ACIL_BYTE_BITS     4'h8
`define ACIL_BIT_ZERO      4'h0
`define ACIL_BIT_ONE       4'h1
`define ACIL_DEV_ADDR      7'h2C

// Warm-up time and its cycle count
`define ACIL_CLK_MHZ       125
`define ACIL_WARMUP_US     2000
`define ACIL_WARMUP_CYC    (`ACIL_WARMUP_US * `ACIL_CLK_MHZ)
`define ACIL_WARM_W        18
`define ACIL_WARM_ONE      18'h00001

`endif

/* File: design/acil_sync.v */
`timescale 1ns/100ps
`include "acil_defines.vh"

module acil_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_b,
  input  wire         ce,
  // Asynchronous levels in
  input  wire [W-1:0] async_in,
  // Synchronised levels and edges out
  output reg  [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  reg [W-1:0] meta;    // First stage, read only by level
  reg [W-1:0] level_d; // Delayed copy for edge finding

  // Two stages, then one more for edges
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta    <= {W{1'b0}};
      level   <= {W{1'b0}};
      level_d <= {W{1'b0}};
    end else if (ce) begin
      meta    <= async_in;
      level   <= meta;
      level_d <= level;
    end
  end

  // Edges look only at the settled stages
  assign rise = level & ~level_d;
  assign fall = ~level & level_d;

endmodule // acil_sync

/* File: testbench/acil_monitor.sv */
`timescale 1ns/100ps
`include "acil_defines.vh"

module acil_monitor #(
  parameter [`ACIL_WARM_W-1:0] WARMUP_CYCLES = `ACIL_WARMUP_CYC
) (
  // Clock and reset
  input wire       clk,
  input wire       rst_b,
  // Link and request pin
  input wire       scl,
  input wire       sda_o,
  input wire       interrupt_request_pin_n_o,
  input wire       interrupt_request_pin_n_oe,
  // Converter core side
  input wire       converter_power_en,
  input wire [1:0] adc_source_sel,
  input wire       battery_voltage_span,
  input wire       charge_current_span,
  input wire       conversion_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Enabled cycles seen, saturating; a start before it reaches WARMUP_CYCLES - 1 is too early
  reg [`ACIL_WARM_W-1:0] warm_cnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      warm_cnt <= {`ACIL_WARM_W{1'b0}};
    end else if (converter_power_en && warm_cnt < WARMUP_CYCLES) begin
      warm_cnt <= warm_cnt + `ACIL_WARM_ONE;
    end
  end

  AST_WARMUP: assert property (conversion_start |-> warm_cnt >= WARMUP_CYCLES - `ACIL_WARM_ONE)
    else $error("conversion started before warm-up ended");
  AST_START_ONE: assert property (conversion_start |=> !conversion_start [*8])
    else $error("start pulse longer than one cycle or repeated");
  AST_START_POWERED: assert property (conversion_start |-> converter_power_en)
    else $error("conversion started while converter disabled");
  AST_POWER_ON_LINK: assert property ($changed(converter_power_en) |-> !scl)
    else $error("enable changed outside a link write");
  AST_SEL_ON_LINK: assert property ($changed(adc_source_sel) |-> !scl)
    else $error("source select changed outside a link write");
  AST_VSPAN_ON_LINK: assert property ($changed(battery_voltage_span) |-> !scl)
    else $error("voltage span changed outside a link write");
  AST_ISPAN_ON_LINK: assert property ($changed(charge_current_span) |-> !scl)
    else $error("current span changed outside a link write");
  AST_IRQ_OPEN_DRAIN: assert property (!interrupt_request_pin_n_o && !sda_o)
    else $error("open-drain output driven high");
  AST_IRQ_RELEASE: assert property ($fell(interrupt_request_pin_n_oe) |-> !scl)
    else $error("request pin released outside a link access");

  // Main scenarios reached
  COV_START: cover property (conversion_start);
  COV_IRQ_SET: cover property ($rose(interrupt_request_pin_n_oe));
  COV_IRQ_CLR: cover property ($fell(interrupt_request_pin_n_oe));
endmodule // acil_monitor

bind acil_adc_irq_ctrl acil_monitor #(.WARMUP_CYCLES(WARMUP_CYCLES)) acil_monitor_inst (
  .clk(clk),
  .rst_b(rst_b),
  .scl(scl),
  .sda_o(sda_o),
  .interrupt_request_pin_n_o(interrupt_request_pin_n_o),
  .interrupt_request_pin_n_oe(interrupt_request_pin_n_oe),
  .converter_power_en(converter_power_en),
  .adc_source_sel(adc_source_sel),
  .battery_voltage_span(battery_voltage_span),
  .charge_current_span(charge_current_span),
  .conversion_start(conversion_start)
);

/* File: testbench/acil_host_model.sv */
`timescale 1ns/100ps
`include "acil_defines.vh"

module acil_host_model (
  // Clock
  input wire clk,
  // Data wire level, pulled up
  input wire sda,
  // Link drive
  output reg scl,
  output reg sda_pull
);
  // Idle link: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic q(input integer n);
    repeat (n) @(negedge clk);
  endtask

  // One bit, 160 ns; data moves only while the clock is low
  task automatic bx(input logic b, output logic s);
    begin
      sda_pull = !b;
      q(5);
      scl = 1'b1;
      q(5);
      s = sda;
      q(5);
      scl = 1'b0;
      q(5);
    end
  endtask

  // Byte MSB first, then the acknowledge slot
  task automatic byx(input logic [7:0] d, input logic ai, output logic [7:0] r, output logic ao);
    integer i;
    begin
      for (i = 7; i >= 0; i--) begin
        bx(d[i], r[i]);
      end
      bx(ai, ao);
    end
  endtask

  // Start or repeated start
  task automatic st;
    begin
      sda_pull = 1'b0;
      q(5);
      scl = 1'b1;
      q(5);
      sda_pull = 1'b1;
      q(5);
      scl = 1'b0;
      q(5);
    end
  endtask

  task automatic sp;
    begin
      sda_pull = 1'b1;
      q(5);
      scl = 1'b1;
      q(5);
      sda_pull = 1'b0;
      q(10);
    end
  endtask

  // Write one register; ok is high when all bytes were acknowledged
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k;
    begin
      st();
      byx({a, 1'b0}, 1'b1, r, k);
      ok = !k;
      byx(p, 1'b1, r, k);
      ok = ok & !k;
      byx(d, 1'b1, r, k);
      ok = ok & !k;
      sp();
    end
  endtask

  // Read one register through a repeated start, ending with a refusal
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    begin
      st();
      byx({`ACIL_DEV_ADDR, 1'b0}, 1'b1, r, k);
      byx(p, 1'b1, r, k);
      st();
      byx({`ACIL_DEV_ADDR, 1'b1}, 1'b1, r, k);
      byx(8'hFF, 1'b1, d, k);
      sp();
    end
  endtask
endmodule // acil_host_model

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`include "acil_defines.vh"

module tb_top;
  localparam CONV = 2000; // Analog conversion length in cycles
  // Design inputs
  reg        clk = 1'b0;
  reg        rst_b = 1'b0;
  reg        converter_done = 1'b0;
  reg  [7:0] converter_data = 8'h00;
  reg        adapter_input = 1'b0;
  reg        usb_power = 1'b0;
  reg        battery_low = 1'b0;
  reg        thermal_alarm = 1'b0;
  reg        charge_timer_expired = 1'b0;
  // Design outputs and wires
  wire       scl, sda_pull, sda_o, sda_oe, irq_o, irq_oe;
  wire       power_en, vspan, ispan, cstart;
  wire [1:0] sel;
  wire       sda = (sda_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  wire       irq_line = (irq_oe && !irq_o) ? 1'b0 : 1'b1;
  // Bench state
  integer    num_errors = 0, checked = 0, starts = 0, k;
  reg  [7:0] rv, conv_val = 8'h00;
  reg        ok;

  always #4 clk = !clk;

  acil_adc_irq_ctrl #(.WARMUP_CYCLES(`ACIL_WARM_W'd20)) acil_adc_irq_ctrl_inst (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .interrupt_request_pin_n_o(irq_o), .interrupt_request_pin_n_oe(irq_oe),
    .converter_power_en(power_en), .adc_source_sel(sel), .battery_voltage_span(vspan),
    .charge_current_span(ispan), .conversion_start(cstart), .converter_done(converter_done),
    .converter_overflow(1'b0), .converter_data(converter_data), .adapter_input(adapter_input),
    .usb_power(usb_power), .battery_low(battery_low), .thermal_alarm(thermal_alarm),
    .charge_timer_expired(charge_timer_expired));

  acil_host_model acil_host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  // Analog core: done drops on start; result comes CONV cycles later, done rises one cycle after it
  initial forever begin
    @(negedge clk);
    if (cstart === 1'b1) begin
      starts = starts + 1;
      converter_done = 1'b0;
      repeat (CONV) @(negedge clk);
      converter_data = conv_val;
      @(negedge clk);
      converter_done = 1'b1;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic w(input logic [7:0] p, input logic [7:0] d);
    begin
      acil_host_model_inst.wr(`ACIL_DEV_ADDR, p, d, ok);
      chk({7'h00, ok}, 8'h01);
    end
  endtask

  task automatic r(input logic [7:0] p, input logic [7:0] e);
    begin
      acil_host_model_inst.rd(p, rv);
      chk(rv, e);
    end
  endtask

  // Bounded wait for the n-th start, then let the conversion finish
  task automatic wait_conv(input integer n);
    integer i;
    begin
      for (i = 0; i < 500 && starts < n; i++) @(negedge clk);
      repeat (CONV + 50) @(negedge clk);
      chk(starts[7:0], n[7:0]);
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Watchdog: the tests take about 40k cycles
  initial begin
    #600000;
    num_errors = num_errors + 1;
    wrap_up();
  end

  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    chk({power_en, cstart, sel, vspan, ispan, 2'b00}, 8'h00);
    for (k = 10; k < 15; k++) r(k[7:0], 8'h00);
    $display("test reset done");
    // Every select code, spans varied alongside
    for (k = 0; k < 4; k++) begin
      w(8'h0A, {k[0], k[1], 4'h0, k[1:0]});
      chk({vspan, ispan, 4'h0, sel}, {k[0], k[1], 4'h0, k[1:0]});
      r(8'h0A, {k[0], k[1], 4'h0, k[1:0]});
    end
    w(8'h0A, 8'h08);
    w(8'h0A, 8'h00);
    chk(starts[7:0], 8'h00);
    $display("test select done");
    // First conversion behind warm-up, interrupt unmasked
    w(8'h0C, 8'h40);
    r(8'h0C, 8'h40);
    conv_val = 8'hA5;
    w(8'h0A, 8'h0C);
    wait_conv(1);
    r(8'h0A, 8'h1C);
    r(8'h0B, 8'hA5);
    chk({7'h00, irq_line}, 8'h00);
    r(8'h0D, 8'h40);
    chk({7'h00, irq_line}, 8'h01);
    r(8'h0D, 8'h00);
    $display("test convert done");
    // Start bit left high gives no new start; 0 then 1 does
    w(8'h0A, 8'h0C);
    wait_conv(1);
    conv_val = 8'h3C;
    w(8'h0A, 8'h05);
    w(8'h0A, 8'h0D);
    r(8'h0A, 8'h0D);
    wait_conv(2);
    r(8'h0B, 8'h3C);
    r(8'h0D, 8'h40);
    $display("test restart done");
    // Each source except conversion done (event six), with all masked
    w(8'h0C, 8'h00);
    for (k = 0; k < 8; k++) begin
      if (k != 6) begin
        case (k)
          0: adapter_input = 1'b1;
          1: adapter_input = 1'b0;
          2: usb_power = 1'b1;
          3: usb_power = 1'b0;
          4: battery_low = 1'b1;
          5: thermal_alarm = 1'b1;
          default: charge_timer_expired = 1'b1;
        endcase
        repeat (10) @(negedge clk);
        chk({7'h00, irq_line}, 8'h01);
        r(8'h0D, 8'h01 << k);
      end
    end
    $display("test sources done");
    // Event arriving while the flag read clears
    thermal_alarm = 1'b0;
    battery_low = 1'b0;
    w(8'h0C, 8'hFF);
    adapter_input = 1'b1;
    usb_power = 1'b1;
    repeat (10) @(negedge clk);
    chk({7'h00, irq_line}, 8'h00);
    fork
      r(8'h0D, 8'h05);
      begin
        repeat (620) @(negedge clk);
        chk({7'h00, irq_line}, 8'h01);
        repeat (30) @(negedge clk);
        thermal_alarm = 1'b1;
      end
    join
    repeat (10) @(negedge clk);
    chk({7'h00, irq_line}, 8'h00);
    r(8'h0D, 8'h20);
    repeat (10) @(negedge clk);
    chk({7'h00, irq_line}, 8'h01);
    $display("test pending done");
    // Read-only result and a foreign address
    w(8'h0B, 8'h55);
    r(8'h0B, 8'h3C);
    acil_host_model_inst.wr(`ACIL_DEV_ADDR ^ 7'h01, 8'h0C, 8'h00, ok);
    chk({7'h00, ok}, 8'h00);
    r(8'h0C, 8'hFF);
    $display("test refusal done");
    wrap_up();
  end
endmodule // tb_top
